// File: design/pcpl_defines.svh
`ifndef PCPL_DEFINES_SVH
`define PCPL_DEFINES_SVH

// Register bus geometry
`define PCPL_ADDR_W        4
`define PCPL_DATA_W        8

// Register offsets
`define PCPL_OFS_SENSE     4'h0
`define PCPL_OFS_ENABLE    4'h1
`define PCPL_OFS_FLAGS     4'h2
`define PCPL_OFS_PCMASK_HI 4'h3
`define PCPL_OFS_PCMASK_LO 4'h4
`define PCPL_OFS_MCU_CTRL  4'h5
`define PCPL_OFS_P0_LATCH  4'h6
`define PCPL_OFS_P0_DIR    4'h7
`define PCPL_OFS_P0_PIN    4'h8
`define PCPL_OFS_P1_LATCH  4'h9
`define PCPL_OFS_P1_DIR    4'hA
`define PCPL_OFS_P1_PIN    4'hB

// Field positions
`define PCPL_SENSE_LO_BIT  0
`define PCPL_SENSE_HI_BIT  1
`define PCPL_EXT_BIT       0
`define PCPL_PC_LO_BIT     6
`define PCPL_PC_HI_BIT     7
`define PCPL_PUD_BIT       4

// Which pad doubles as the external interrupt pin
`define PCPL_EXT_PIN       8

// Reset values
`define PCPL_RST_BYTE      8'h00
`define PCPL_RST_SENSE     2'h0

`endif

// File: design/pcpl_pkg.sv
`default_nettype none

package pcpl_pkg;

    typedef enum logic [1:0] {
        PCPL_SENSE_LOW  = 2'b00,
        PCPL_SENSE_ANY  = 2'b01,
        PCPL_SENSE_FALL = 2'b10,
        PCPL_SENSE_RISE = 2'b11
    } pcpl_sense_t;

endpackage : pcpl_pkg

`default_nettype wire

// File: design/pcpl_sync2.sv
`default_nettype none

module pcpl_sync2 #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // pcpl_sync2

`default_nettype wire

// File: design/pcpl_port.sv
`default_nettype none

module pcpl_port #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         wr_latch,
    input  wire logic         wr_dir,
    input  wire logic         wr_toggle,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         pull_dis,
    output logic      [W-1:0] latch_q,
    output logic      [W-1:0] dir_q,
    output logic      [W-1:0] pad_o,
    output logic      [W-1:0] pad_oe,
    output logic      [W-1:0] pull_en
);

    // Latch writes replace the whole byte; pin writes toggle only the bits written as one
    always_ff @(posedge clk) begin
        if (srst) begin
            latch_q <= '0;
        end else if (wr_latch) begin
            latch_q <= wr_data;
        end else if (wr_toggle) begin
            latch_q <= latch_q ^ wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dir_q <= '0;
        end else if (wr_dir) begin
            dir_q <= wr_data;
        end
    end

    // Reset gates the drivers directly so pads float even without a clock
    assign pad_o  = latch_q;
    assign pad_oe = dir_q & {W{~srst}};
    assign pull_en = ~dir_q & latch_q & {W{~pull_dis}} & {W{~srst}};

endmodule // pcpl_port

`default_nettype wire

// File: design/pcpl_top.sv
`include "pcpl_defines.svh"
`default_nettype none

module pcpl_top (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [`PCPL_ADDR_W-1:0] addr,
    input  wire logic [`PCPL_DATA_W-1:0] wr_data,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [`PCPL_DATA_W-1:0] rd_data_q,
    input  wire logic                    global_irq_en,
    input  wire logic                    ack_ext,
    input  wire logic                    ack_pc_lo,
    input  wire logic                    ack_pc_hi,
    output logic                         irq_ext_q,
    output logic                         pc_vector_lo_q,
    output logic                         pc_vector_hi_q,
    output logic                         wake_req,
    input  wire logic [15:0]             pin_i,
    output logic      [15:0]             pin_o,
    output logic      [15:0]             pin_oe,
    output logic      [15:0]             pin_pullup
);

    logic [15:0]         pin_s;
    logic [15:0]         pin_prev_q;
    pcpl_pkg::pcpl_sense_t sense_q;
    logic                ext_irq_pin_enable_q;
    logic                pc_group_lo_enable_q;
    logic                pc_group_hi_enable_q;
    logic                ext_irq_flag_q;
    logic                ext_irq_flag_d;
    logic                pc_group_lo_flag_q;
    logic                pc_group_lo_flag_d;
    logic                pc_group_hi_flag_q;
    logic                pc_group_hi_flag_d;
    logic [7:0]          pc_pin_mask_hi_q;
    logic [7:0]          pc_pin_mask_lo_q;
    logic                pullup_disable_all_q;
    logic [7:0]          p0_latch;
    logic [7:0]          p0_dir;
    logic [7:0]          p1_latch;
    logic [7:0]          p1_dir;
    logic                ext_cur;
    logic                ext_prev;
    logic                ext_trig;
    logic                pc_lo_hit;
    logic                pc_hi_hit;
    logic                sense_low;
    logic                wr_flags;
    logic [7:0]          rd_mux;

    function automatic logic group_change(
        input logic [7:0] cur,
        input logic [7:0] prev,
        input logic [7:0] mask,
        input logic       en
    );
        group_change = en & (|((cur ^ prev) & mask));
    endfunction

    function automatic logic hit(input logic [`PCPL_ADDR_W-1:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Pads are read through the synchroniser whatever the direction
    pcpl_sync2 #(
        .W (16)
    ) u_sync (
        .clk     (clk),
        .srst    (srst),
        .async_i (pin_i),
        .sync_o  (pin_s)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_prev_q <= '0;
        end else begin
            pin_prev_q <= pin_s;
        end
    end

    // Register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            sense_q <= pcpl_pkg::PCPL_SENSE_LOW;
        end else if (wr_en && hit(`PCPL_OFS_SENSE)) begin
            sense_q <= pcpl_pkg::pcpl_sense_t'(wr_data[`PCPL_SENSE_HI_BIT:`PCPL_SENSE_LO_BIT]);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_irq_pin_enable_q <= 1'b0;
            pc_group_lo_enable_q <= 1'b0;
            pc_group_hi_enable_q <= 1'b0;
        end else if (wr_en && hit(`PCPL_OFS_ENABLE)) begin
            ext_irq_pin_enable_q <= wr_data[`PCPL_EXT_BIT];
            pc_group_lo_enable_q <= wr_data[`PCPL_PC_LO_BIT];
            pc_group_hi_enable_q <= wr_data[`PCPL_PC_HI_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pc_pin_mask_hi_q <= `PCPL_RST_BYTE;
            pc_pin_mask_lo_q <= `PCPL_RST_BYTE;
        end else if (wr_en && hit(`PCPL_OFS_PCMASK_HI)) begin
            pc_pin_mask_hi_q <= wr_data;
        end else if (wr_en && hit(`PCPL_OFS_PCMASK_LO)) begin
            pc_pin_mask_lo_q <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pullup_disable_all_q <= 1'b0;
        end else if (wr_en && hit(`PCPL_OFS_MCU_CTRL)) begin
            pullup_disable_all_q <= wr_data[`PCPL_PUD_BIT];
        end
    end

    // Event detection on synchronised samples
    assign ext_cur   = pin_s[`PCPL_EXT_PIN];
    assign ext_prev  = pin_prev_q[`PCPL_EXT_PIN];
    assign sense_low = (sense_q == pcpl_pkg::PCPL_SENSE_LOW);

    always_comb begin
        unique case (sense_q)
            pcpl_pkg::PCPL_SENSE_LOW:  ext_trig = 1'b0;
            pcpl_pkg::PCPL_SENSE_ANY:  ext_trig = ext_cur ^ ext_prev;
            pcpl_pkg::PCPL_SENSE_FALL: ext_trig = ext_prev & ~ext_cur;
            pcpl_pkg::PCPL_SENSE_RISE: ext_trig = ~ext_prev & ext_cur;
        endcase
    end

    assign pc_lo_hit = group_change(pin_s[7:0], pin_prev_q[7:0], pc_pin_mask_lo_q,
                                    pc_group_lo_enable_q);
    assign pc_hi_hit = group_change(pin_s[15:8], pin_prev_q[15:8], pc_pin_mask_hi_q,
                                    pc_group_hi_enable_q);
    assign wr_flags  = wr_en && hit(`PCPL_OFS_FLAGS);

    // Flags: a new event outranks a clear in the same cycle
    always_comb begin
        ext_irq_flag_d = ext_irq_flag_q;
        if (sense_low) begin
            ext_irq_flag_d = 1'b0;
        end else if (ext_trig) begin
            ext_irq_flag_d = 1'b1;
        end else if (ack_ext || (wr_flags && wr_data[`PCPL_EXT_BIT])) begin
            ext_irq_flag_d = 1'b0;
        end
    end

    always_comb begin
        pc_group_lo_flag_d = pc_group_lo_flag_q;
        if (pc_lo_hit) begin
            pc_group_lo_flag_d = 1'b1;
        end else if (ack_pc_lo || (wr_flags && wr_data[`PCPL_PC_LO_BIT])) begin
            pc_group_lo_flag_d = 1'b0;
        end
    end

    always_comb begin
        pc_group_hi_flag_d = pc_group_hi_flag_q;
        if (pc_hi_hit) begin
            pc_group_hi_flag_d = 1'b1;
        end else if (ack_pc_hi || (wr_flags && wr_data[`PCPL_PC_HI_BIT])) begin
            pc_group_hi_flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_irq_flag_q     <= 1'b0;
            pc_group_lo_flag_q <= 1'b0;
            pc_group_hi_flag_q <= 1'b0;
        end else begin
            ext_irq_flag_q     <= ext_irq_flag_d;
            pc_group_lo_flag_q <= pc_group_lo_flag_d;
            pc_group_hi_flag_q <= pc_group_hi_flag_d;
        end
    end

    // Requests to the core, each on its own vector line
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_ext_q      <= 1'b0;
            pc_vector_lo_q <= 1'b0;
            pc_vector_hi_q <= 1'b0;
        end else begin
            irq_ext_q      <= global_irq_en & ext_irq_pin_enable_q &
                              (sense_low ? ~ext_cur : ext_irq_flag_d);
            pc_vector_lo_q <= global_irq_en & pc_group_lo_enable_q & pc_group_lo_flag_d;
            pc_vector_hi_q <= global_irq_en & pc_group_hi_enable_q & pc_group_hi_flag_d;
        end
    end

    // Raw pads on purpose: this path must work while the clock is stopped
    assign wake_req = group_change(pin_i[7:0], pin_prev_q[7:0], pc_pin_mask_lo_q,
                                   pc_group_lo_enable_q) |
                      group_change(pin_i[15:8], pin_prev_q[15:8], pc_pin_mask_hi_q,
                                   pc_group_hi_enable_q) |
                      (sense_low & ext_irq_pin_enable_q & ~pin_i[`PCPL_EXT_PIN]);

    // Two ports of three locations each
    pcpl_port #(
        .W (8)
    ) u_port0 (
        .clk       (clk),
        .srst      (srst),
        .wr_latch  (wr_en && hit(`PCPL_OFS_P0_LATCH)),
        .wr_dir    (wr_en && hit(`PCPL_OFS_P0_DIR)),
        .wr_toggle (wr_en && hit(`PCPL_OFS_P0_PIN)),
        .wr_data   (wr_data),
        .pull_dis  (pullup_disable_all_q),
        .latch_q   (p0_latch),
        .dir_q     (p0_dir),
        .pad_o     (pin_o[7:0]),
        .pad_oe    (pin_oe[7:0]),
        .pull_en   (pin_pullup[7:0])
    );

    pcpl_port #(
        .W (8)
    ) u_port1 (
        .clk       (clk),
        .srst      (srst),
        .wr_latch  (wr_en && hit(`PCPL_OFS_P1_LATCH)),
        .wr_dir    (wr_en && hit(`PCPL_OFS_P1_DIR)),
        .wr_toggle (wr_en && hit(`PCPL_OFS_P1_PIN)),
        .wr_data   (wr_data),
        .pull_dis  (pullup_disable_all_q),
        .latch_q   (p1_latch),
        .dir_q     (p1_dir),
        .pad_o     (pin_o[15:8]),
        .pad_oe    (pin_oe[15:8]),
        .pull_en   (pin_pullup[15:8])
    );

    // Read path; unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (addr)
            `PCPL_OFS_SENSE:     rd_mux = {6'h00, sense_q};
            `PCPL_OFS_ENABLE:    rd_mux = {pc_group_hi_enable_q, pc_group_lo_enable_q,
                                           5'h00, ext_irq_pin_enable_q};
            `PCPL_OFS_FLAGS:     rd_mux = {pc_group_hi_flag_q, pc_group_lo_flag_q,
                                           5'h00, ext_irq_flag_q};
            `PCPL_OFS_PCMASK_HI: rd_mux = pc_pin_mask_hi_q;
            `PCPL_OFS_PCMASK_LO: rd_mux = pc_pin_mask_lo_q;
            `PCPL_OFS_MCU_CTRL:  rd_mux = {3'h0, pullup_disable_all_q, 4'h0};
            `PCPL_OFS_P0_LATCH:  rd_mux = p0_latch;
            `PCPL_OFS_P0_DIR:    rd_mux = p0_dir;
            `PCPL_OFS_P0_PIN:    rd_mux = pin_s[7:0];
            `PCPL_OFS_P1_LATCH:  rd_mux = p1_latch;
            `PCPL_OFS_P1_DIR:    rd_mux = p1_dir;
            `PCPL_OFS_P1_PIN:    rd_mux = pin_s[15:8];
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_en ? rd_mux : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_ext_low_level: assert property (
        sense_low && ext_irq_pin_enable_q && global_irq_en && !ext_cur |=> irq_ext_q)
        else $error("low level request missing");

    a_ext_flag_low: assert property (
        sense_low |=> !ext_irq_flag_q)
        else $error("external flag set in low level sense");

    a_ext_rise_set: assert property (
        sense_q == pcpl_pkg::PCPL_SENSE_RISE && !ext_prev && ext_cur |=> ext_irq_flag_q)
        else $error("rising edge did not set flag");

    a_ext_fall_quiet: assert property (
        sense_q == pcpl_pkg::PCPL_SENSE_FALL && !ext_prev && ext_cur && !ext_irq_flag_q
        |=> !ext_irq_flag_q)
        else $error("rising edge set flag in falling sense");

    a_pc_lo_set: assert property (
        pc_group_lo_enable_q && |((pin_s[7:0] ^ pin_prev_q[7:0]) & pc_pin_mask_lo_q)
        |=> pc_group_lo_flag_q)
        else $error("low group change lost");

    a_pc_hi_gate: assert property (
        !pc_group_hi_enable_q && !pc_group_hi_flag_q |=> !pc_group_hi_flag_q)
        else $error("high group flag set while disabled");

    a_flag_w1c: assert property (
        wr_flags && wr_data[`PCPL_PC_HI_BIT] && !pc_hi_hit |=> !pc_group_hi_flag_q)
        else $error("write one did not clear flag");

    a_vector_gate: assert property (
        !global_irq_en |=> !irq_ext_q && !pc_vector_lo_q && !pc_vector_hi_q)
        else $error("request without global enable");

    a_pin_toggle: assert property (
        wr_en && hit(`PCPL_OFS_P0_PIN) |=> p0_latch == ($past(p0_latch) ^ $past(wr_data)))
        else $error("pin write did not toggle latch");

    a_reset_float: assert property (disable iff (1'b0)
        srst |-> pin_oe == 16'h0000 && pin_pullup == 16'h0000)
        else $error("pads driven during reset");

    a_read_once: assert property (
        rd_en ##1 !rd_en |=> rd_data_q == 8'h00)
        else $error("read data held too long");

    c_ext_irq: cover property (ext_trig ##1 irq_ext_q);
    c_pc_lo_ack: cover property (pc_vector_lo_q ##[1:4] ack_pc_lo);
    c_toggle_rd: cover property (wr_en && hit(`PCPL_OFS_P1_PIN) ##1 rd_en);

endmodule // pcpl_top

`default_nettype wire

// File: bench/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk           = 1'b0;
    logic        srst          = 1'b1;
    logic [3:0]  addr          = 4'h0;
    logic [7:0]  wr_data       = 8'h00;
    logic        wr_en         = 1'b0;
    logic        rd_en         = 1'b0;
    logic        global_irq_en = 1'b0;
    logic [2:0]  ack           = 3'h0;
    logic [15:0] ext_v         = 16'h0000;
    logic [7:0]  rd_data_q;
    logic        irq_ext_q;
    logic        pc_vector_lo_q;
    logic        pc_vector_hi_q;
    logic        wake_req;
    logic [15:0] pin_i;
    logic [15:0] pin_o;
    logic [15:0] pin_oe;
    logic [15:0] pin_pullup;
    int          errors          = 0;
    int          samples_checked = 0;

    // Driven pads read back their own level, so software can raise interrupts
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_v);

    always #4 clk = ~clk;

    pcpl_top u_pcpl_top (
        .clk            (clk),
        .srst           (srst),
        .addr           (addr),
        .wr_data        (wr_data),
        .wr_en          (wr_en),
        .rd_en          (rd_en),
        .rd_data_q      (rd_data_q),
        .global_irq_en  (global_irq_en),
        .ack_ext        (ack[0]),
        .ack_pc_lo      (ack[1]),
        .ack_pc_hi      (ack[2]),
        .irq_ext_q      (irq_ext_q),
        .pc_vector_lo_q (pc_vector_lo_q),
        .pc_vector_hi_q (pc_vector_hi_q),
        .wake_req       (wake_req),
        .pin_i          (pin_i),
        .pin_o          (pin_o),
        .pin_oe         (pin_oe),
        .pin_pullup     (pin_pullup)
    );

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk);
        addr    <= 4'(a);
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input int a, output logic [7:0] d);
        @(posedge clk);
        addr  <= 4'(a);
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data_q;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] ff_exp(input int a);
        case (a)
            0: return 8'h03;
            1, 2: return 8'hC1;
            5: return 8'h10;
            12: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction

    // Fill every register except the flags and pin offsets, read all back, then reset mid-run
    task automatic t_regs;
        logic [7:0] d;
        for (int a = 0; a < 13; a++) if (a != 2 && a != 8 && a != 11) wr(a, 8'hFF);
        for (int a = 0; a < 13; a++) begin
            rd(a, d);
            chk("reg after fill", {8'h00, d}, {8'h00, ff_exp(a)});
        end
        wr(5, 8'h00);
        wr(10, 8'h00);
        @(posedge clk);
        srst <= 1'b1;
        #1 chk("oe in reset", pin_oe, 16'h0000);
        chk("pullup in reset", pin_pullup, 16'h0000);
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 13; a++) begin
            rd(a, d);
            chk("reg after reset", {8'h00, d}, 16'h0000);
        end
    endtask

    task automatic t_port;
        logic [7:0] d;
        for (int p = 0; p < 2; p++) begin
            wr(6 + 3 * p, 8'h55);
            wr(7 + 3 * p, 8'h0F);
            #1 chk("drive", 16'(pin_o >> (8 * p)) & 16'h00FF, 16'h0055);
            chk("oe", 16'(pin_oe >> (8 * p)) & 16'h00FF, 16'h000F);
            chk("pullup", 16'(pin_pullup >> (8 * p)) & 16'h00FF, 16'h0050);
            wr(8 + 3 * p, 8'h03);
            rd(6 + 3 * p, d);
            chk("toggled latch", {8'h00, d}, 16'h0056);
            cyc(2);
            rd(8 + 3 * p, d);
            chk("pin sample", {8'h00, d}, 16'h0006);
            wr(5, 8'h10);
            #1 chk("pullup off", pin_pullup, 16'h0000);
            wr(5, 8'h00);
            wr(6 + 3 * p, 8'h00);
            wr(7 + 3 * p, 8'h00);
        end
    endtask

    task automatic t_pc(input int h);
        logic [7:0] d;
        logic [7:0] en;
        int         idx;
        en  = (h != 0) ? 8'h80 : 8'h40;
        idx = (h != 0) ? 9 : 1;
        global_irq_en <= 1'b1;
        wr(1, en);
        wr((h != 0) ? 3 : 4, 8'h02);
        ext_v[idx-1] <= ~ext_v[idx-1];
        cyc(5);
        rd(2, d);
        chk("masked pin flag", {8'h00, d}, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                @(posedge clk);
                global_irq_en <= 1'b0;
            end
            ext_v[idx] <= ~ext_v[idx];
            cyc(1);
            chk("wake on change", 16'(wake_req), 16'h0001);
            cyc(3);
            chk("group request", 16'((h != 0) ? pc_vector_hi_q : pc_vector_lo_q),
                16'(k != 2));
            rd(2, d);
            chk("group flag", {8'h00, d}, {8'h00, en});
            if (k == 0) begin
                @(posedge clk);
                ack[1 + h] <= 1'b1;
                @(posedge clk);
                ack[1 + h] <= 1'b0;
                #1 chk("request after entry", 16'(pc_vector_hi_q | pc_vector_lo_q),
                       16'h0000);
            end else begin
                wr(2, en);
            end
            rd(2, d);
            chk("flag cleared", {8'h00, d}, 16'h0000);
        end
        wr(1, 8'h00);
        wr((h != 0) ? 3 : 4, 8'h00);
    endtask

    task automatic t_ext;
        logic [7:0] d;
        logic       exp_hit;
        global_irq_en <= 1'b1;
        ext_v[8] <= 1'b1;
        wr(1, 8'h01);
        for (int s = 1; s < 4; s++) begin
            wr(0, 8'(s));
            cyc(4);
            wr(2, 8'h01);
            for (int ph = 0; ph < 3; ph++) begin
                // Third phase is a two-cycle low pulse, both edges visible
                ext_v[8] <= (ph == 1);
                if (ph == 2) begin
                    cyc(2);
                    ext_v[8] <= 1'b1;
                end
                cyc(5);
                exp_hit = (ph == 2 || s == 1 || (s == 2) == (ph == 0));
                chk("ext request", 16'(irq_ext_q), 16'(exp_hit));
                rd(2, d);
                chk("ext flag", 16'(d[0]), 16'(exp_hit));
                wr(2, 8'h01);
            end
        end
        wr(0, 8'h00);
        // Level is held far longer than any instruction would take
        ext_v[8] <= 1'b0;
        cyc(4);
        repeat (20) begin
            cyc(1);
            chk("level request", 16'(irq_ext_q), 16'h0001);
        end
        rd(2, d);
        chk("level flag", 16'(d[0]), 16'h0000);
        chk("level wake", 16'(wake_req), 16'h0001);
        @(posedge clk);
        global_irq_en <= 1'b0;
        cyc(2);
        chk("level gated", 16'(irq_ext_q), 16'h0000);
        @(posedge clk);
        global_irq_en <= 1'b1;
        ext_v[8] <= 1'b1;
        cyc(4);
        chk("level released", 16'(irq_ext_q), 16'h0000);
        chk("wake released", 16'(wake_req), 16'h0000);
    endtask

    // The pin is its own source here: toggling the latch raises the request
    task automatic t_soft;
        logic [7:0] d;
        wr(0, 8'h01);
        wr(10, 8'h01);
        cyc(5);
        wr(2, 8'h01);
        wr(11, 8'h01);
        cyc(5);
        rd(2, d);
        chk("driven pin flag", 16'(d[0]), 16'h0001);
        chk("driven pin request", 16'(irq_ext_q), 16'h0001);
        @(posedge clk);
        ack[0] <= 1'b1;
        @(posedge clk);
        ack[0] <= 1'b0;
        rd(2, d);
        chk("flag after entry", 16'(d[0]), 16'h0000);
    endtask

    task automatic wrap_up;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_port();
        t_pc(0);
        t_pc(1);
        t_ext();
        t_soft();
        wrap_up();
    end

    // Whole run is well under two thousand cycles
    initial begin
        #(8 * 20000);
        errors++;
        wrap_up();
    end
endmodule // testbench

`default_nettype wire
